/* verilog/fsrs_top.sv */
// receiver restart control and mode sequencer of the fsk receiver
//
// Overview of operation
// - correction once per packet after each restart
// - trigger select picks correction start event
// - auto gain corrects; else manual gain applies
// - restart command ignored unless mode settled
// - auto restart mode 00: never restart
// - mode 01: restart after fifo empty, wait
// - mode 10: as 01 plus relock delay
// - collision restart on sudden rssi rise
// - collision threshold in 1 dB steps
// - sequencer runs only outside spread spectrum
// - start from sleep/standby, remember mode
// - stop forces sequencer off anytime
// - off from rest choice restores initial mode
// - idle: low power, only timer one
// - transmit state tx on, receive rx on
// - got frame: receiver stays on
// - rest choice goes to off or idle
// - any of three timeouts enters expiry action
// - quiet mode bit: 0 standby, 1 sleep
// - rest bit: 0 off, 1 idle
// - launch route picks first state
// - timeout after value times 16 bit periods
`timescale 1ns/100ps
module fsrs_top
#(
  parameter int RELOCK_CYC = fsrs_pkg::RELOCK_CYC_DEF
)
(
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    reset,
  // register port
  input  wire logic [fsrs_pkg::AW-1:0] addr,
  input  wire logic [fsrs_pkg::DW-1:0] wdata,
  input  wire logic                    we,
  input  wire logic                    re,
  output logic      [fsrs_pkg::DW-1:0] rdata,
  // chip status
  input  wire logic                    mode_settled_flag,
  input  wire logic                    spread_mode,
  input  wire logic [2:0]              host_mode,
  input  wire logic [7:0]              rssi_value,
  input  wire fsrs_pkg::fsrs_rx_ev_t   rx_ev,
  // receiver control
  output fsrs_pkg::fsrs_rx_ctl_t       rx_ctl,
  output logic      [2:0]              chip_mode,
  output logic                         seq_active
);
  import fsrs_pkg::*;

  fsrs_state_t s_reg;
  fsrs_state_t s_next;
  logic        man_go;
  logic        auto_go;
  logic        coll_go;
  logic        exp_go;

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    logic       wr_rx;
    logic       wr_seq;
    logic       rx_on;
    logic       event_hit;
    logic [8:0] rise_lim;
    wr_rx     = we && (addr == ADR_RX_CFG);
    wr_seq    = we && (addr == ADR_SEQ_CFG);
    rx_on     = (s_reg.mode == MODE_RX);
    event_hit = 1'b0;
    rise_lim  = {1'b0, s_reg.rssi_prev} + {1'b0, s_reg.coll_thr};
    s_next    = s_reg;
    s_next.ctl.rx_restart      = 1'b0;
    s_next.ctl.restart_relock  = 1'b0;
    s_next.ctl.gain_corr_start = 1'b0;
    s_next.ctl.freq_corr_start = 1'b0;
    s_next.ctl.timeout_irq     = '0;
    s_next.rdata = '0;
    // register writes; command bits are never stored
    if (wr_rx)
      s_next.rx_cfg = wdata & RXC_STORE_MASK;
    if (we && addr == ADR_SYNC_CFG)
      s_next.sync_cfg = wdata[1:0];
    if (wr_seq)
      s_next.seq_cfg = wdata & SEQ_STORE_MASK;
    if (we && addr == ADR_FRONT_AMP)
      s_next.gain = wdata[2:0];
    if (we && addr == ADR_COLL_THR)
      s_next.coll_thr = wdata;
    if (we && addr == ADR_POST_WAIT)
      s_next.post_wait = wdata;
    for (int i = 0; i < NUM_TO; i++)
    begin
      if (we && addr == ADR_TO_BASE + 6'(i) * ADR_STEP)
        s_next.to_val[i] = wdata;
      if (re && addr == ADR_TO_BASE + 6'(i) * ADR_STEP)
        s_next.rdata = s_reg.to_val[i];
    end
    // register reads, data in the following cycle
    if (re)
    begin
      case (addr)
        ADR_RX_CFG    : s_next.rdata = s_reg.rx_cfg;
        ADR_SYNC_CFG  : s_next.rdata = {6'h00, s_reg.sync_cfg};
        ADR_SEQ_CFG   : s_next.rdata = s_reg.seq_cfg;
        ADR_FRONT_AMP : s_next.rdata = {5'h00, s_reg.gain};
        ADR_COLL_THR  : s_next.rdata = s_reg.coll_thr;
        ADR_POST_WAIT : s_next.rdata = s_reg.post_wait;
        ADR_STATUS    :
        begin
          s_next.rdata[STAT_ACTIVE] = (s_reg.seq != seq_halted_state);
          s_next.rdata[STAT_STATE_LO +: 3] = s_reg.seq;
          s_next.rdata[2:0] = s_reg.mode;
        end
        default       : ;
      endcase
    end
    // gain source follows the auto gain bit
    s_next.ctl.gain_manual = !s_next.rx_cfg[RXC_AGC];
    s_next.ctl.front_gain  = s_next.gain;
    // manual restart, taken only while the mode has settled
    man_go = wr_rx && (wdata[RXC_KEEP] || wdata[RXC_RELOCK]) && mode_settled_flag;
    // collision: rise above previous sample by more than the threshold
    coll_go = 1'b0;
    if (rx_ev.bit_tick)
    begin
      s_next.rssi_prev = rssi_value;
      coll_go = s_reg.rx_cfg[RXC_COLL] && rx_on && ({1'b0, rssi_value} > rise_lim);
    end
    // automatic restart after a valid packet
    auto_go = 1'b0;
    case (s_reg.ar)
      ar_idle  :
        if (rx_on && rx_ev.packet_ready_flag && s_reg.sync_cfg != AR_OFF)
          s_next.ar = ar_empty;
      ar_empty :
        if (rx_ev.fifo_empty)
        begin
          s_next.ar     = ar_delay;
          s_next.ar_cnt = {8'h00, s_reg.post_wait};
        end
      ar_delay :
        if (s_reg.ar_cnt == '0)
        begin
          if (s_reg.sync_cfg == AR_RELOCK)
          begin
            s_next.ar     = ar_lock;
            s_next.ar_cnt = 16'(RELOCK_CYC);
          end
          else
          begin
            s_next.ar = ar_idle;
            auto_go   = 1'b1;
          end
        end
        else if (rx_ev.bit_tick)
          s_next.ar_cnt = s_reg.ar_cnt - 16'h0001;
      ar_lock  :
        if (s_reg.ar_cnt == '0)
        begin
          s_next.ar = ar_idle;
          auto_go   = 1'b1;
        end
        else
          s_next.ar_cnt = s_reg.ar_cnt - 16'h0001;
      default  : s_next.ar = ar_idle;
    endcase
    if (!rx_on || s_reg.sync_cfg == AR_OFF)
    begin
      s_next.ar = ar_idle;
      auto_go   = 1'b0;
    end
    // sequencer
    exp_go = (s_reg.seq == seq_listen_expiry_state) && s_reg.seq_cfg[SEQ_EXP_RESTART];
    case (s_reg.seq)
      seq_halted_state        :
        if (wr_seq && wdata[SEQ_START] && !wdata[SEQ_STOP]
            && (host_mode == MODE_SLEEP || host_mode == MODE_STBY))
        begin
          s_next.init_mode = host_mode;
          s_next.seq_ran   = 1'b1;
          case (wdata[SEQ_ROUTE_LO +: 2])
            RT_REST : s_next.seq = seq_rest_choice_state;
            RT_RX   : s_next.seq = seq_rx_state;
            RT_TX   : s_next.seq = seq_tx_state;
            default : s_next.seq = seq_fifo_wait_state;
          endcase
        end
      seq_idle_state          :
        if (rx_ev.seq_timer_one)
          s_next.seq = seq_rx_state;
      seq_fifo_wait_state     :
        if (rx_ev.fifo_thr_irq)
          s_next.seq = seq_tx_state;
      seq_tx_state            :
        if (rx_ev.packet_sent)
          s_next.seq = seq_rest_choice_state;
      seq_rx_state            :
        if (rx_ev.seq_timer_two)
          s_next.seq = seq_rest_choice_state;
        else if (|s_reg.ctl.timeout_irq)
          s_next.seq = seq_listen_expiry_state;
        else if (rx_ev.packet_ready_flag)
          s_next.seq = seq_got_frame_state;
      seq_got_frame_state     :
        if (rx_ev.fifo_empty)
          s_next.seq = seq_rest_choice_state;
      seq_rest_choice_state   :
        s_next.seq = s_reg.seq_cfg[SEQ_REST] ? seq_idle_state : seq_halted_state;
      seq_listen_expiry_state :
        s_next.seq = exp_go ? seq_rx_state : seq_rest_choice_state;
      default                 : s_next.seq = seq_halted_state;
    endcase
    if ((wr_seq && wdata[SEQ_STOP]) || spread_mode)
      s_next.seq = seq_halted_state;
    if (s_reg.seq_ran && s_reg.seq == seq_halted_state && host_mode != s_reg.init_mode)
      s_next.seq_ran = 1'b0;
    // chip mode
    case (s_next.seq)
      seq_halted_state        :
        s_next.mode = s_next.seq_ran ? s_next.init_mode : host_mode;
      seq_idle_state          :
        s_next.mode = s_next.seq_cfg[SEQ_QUIET] ? MODE_SLEEP : MODE_STBY;
      seq_tx_state            : s_next.mode = MODE_TX;
      seq_rx_state,
      seq_got_frame_state,
      seq_listen_expiry_state : s_next.mode = MODE_RX;
      default                 : s_next.mode = s_next.init_mode;
    endcase
    // restart output
    if (man_go || auto_go || coll_go || exp_go)
    begin
      s_next.ctl.rx_restart     = 1'b1;
      s_next.ctl.restart_relock = man_go ? wdata[RXC_RELOCK]
                                         : (auto_go && s_reg.sync_cfg == AR_RELOCK);
    end
    // receive timeouts counted in bit periods since receiver turn-on or restart
    if (rx_on && rx_ev.bit_tick && s_reg.bit_cnt != '1)
      s_next.bit_cnt = s_reg.bit_cnt + 12'h001;
    for (int i = 0; i < NUM_TO; i++)
    begin
      if ((i == 0 && rx_ev.rssi_irq) || (i == 1 && rx_ev.lead_in_found_flag)
          || (i == 2 && rx_ev.sync_found_flag))
        s_next.seen[i] = 1'b1;
      else if (rx_on && rx_ev.bit_tick && !s_reg.seen[i] && s_reg.to_val[i] != '0
               && s_next.bit_cnt == 12'(s_reg.to_val[i]) * 12'(TIMEOUT_SCALE))
      begin
        s_next.ctl.timeout_irq[i] = 1'b1;
        s_next.seen[i] = 1'b1;
      end
    end
    // correction start on the selected event
    case (s_reg.rx_cfg[2:0])
      TRIG_RSSI : event_hit = rx_ev.rssi_irq;
      TRIG_PRE  : event_hit = rx_ev.lead_in_found_flag;
      TRIG_BOTH : event_hit = rx_ev.rssi_irq || rx_ev.lead_in_found_flag;
      default   : event_hit = 1'b0;
    endcase
    if (s_reg.arm && rx_on && event_hit)
    begin
      s_next.arm = 1'b0;
      s_next.ctl.gain_corr_start = s_reg.rx_cfg[RXC_AGC];
      s_next.ctl.freq_corr_start = s_reg.rx_cfg[RXC_AGC] && s_reg.rx_cfg[RXC_AFC];
    end
    // receiver turn-on or restart rearms correction and timeouts
    if (s_next.ctl.rx_restart || (s_next.mode == MODE_RX && !rx_on))
    begin
      s_next.arm     = 1'b1;
      s_next.bit_cnt = '0;
      s_next.seen    = '0;
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (reset)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign rdata      = s_reg.rdata;
  assign rx_ctl     = s_reg.ctl;
  assign chip_mode  = s_reg.mode;
  assign seq_active = (s_reg.seq != seq_halted_state);

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_restart_settled;
    (we && addr == ADR_RX_CFG && wdata[RXC_KEEP] && !mode_settled_flag
     && !auto_go && !coll_go && !exp_go) |=> !rx_ctl.rx_restart;
  endproperty
  a_restart_settled: assert property (p_restart_settled)
    else $error("restart taken without settled mode");

  property p_stop;
    (we && addr == ADR_SEQ_CFG && wdata[SEQ_STOP]) |=> !seq_active ##1 !seq_active;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop did not halt the sequencer");

  property p_start_rx;
    (!seq_active && we && addr == ADR_SEQ_CFG && wdata[SEQ_START] && !wdata[SEQ_STOP]
     && wdata[SEQ_ROUTE_LO +: 2] == RT_RX && !spread_mode && host_mode == MODE_STBY)
    |=> chip_mode == MODE_RX && s_reg.init_mode == MODE_STBY;
  endproperty
  a_start_rx: assert property (p_start_rx)
    else $error("start to receive failed");

  property p_spread;
    spread_mode |=> !seq_active;
  endproperty
  a_spread: assert property (p_spread)
    else $error("sequencer active in spread spectrum mode");

  property p_idle_mode;
    (s_reg.seq == seq_idle_state)
    |-> chip_mode == (s_reg.seq_cfg[SEQ_QUIET] ? MODE_SLEEP : MODE_STBY);
  endproperty
  a_idle_mode: assert property (p_idle_mode)
    else $error("idle state in wrong chip mode");

  property p_rest;
    (s_reg.seq == seq_rest_choice_state && !spread_mode && !we)
    |=> s_reg.seq == ($past(s_reg.seq_cfg[SEQ_REST]) ? seq_idle_state : seq_halted_state);
  endproperty
  a_rest: assert property (p_rest)
    else $error("rest choice went to wrong state");

  property p_halt_init;
    (s_reg.seq == seq_rest_choice_state && !s_reg.seq_cfg[SEQ_REST] && !spread_mode)
    |=> chip_mode == $past(s_reg.init_mode);
  endproperty
  a_halt_init: assert property (p_halt_init)
    else $error("initial mode not restored");

  property p_auto_off;
    (s_reg.sync_cfg == AR_OFF) |-> !auto_go;
  endproperty
  a_auto_off: assert property (p_auto_off)
    else $error("auto restart while disabled");

  property p_corr_once;
    // a restart in the same cycle rearms at once
    rx_ctl.gain_corr_start |-> $past(s_reg.arm) && (!s_reg.arm || rx_ctl.rx_restart);
  endproperty
  a_corr_once: assert property (p_corr_once)
    else $error("correction started twice");

  property p_trig_none;
    (s_reg.rx_cfg[2:0] == TRIG_NONE) |=> !rx_ctl.gain_corr_start;
  endproperty
  a_trig_none: assert property (p_trig_none)
    else $error("correction without trigger");

  property p_tx_on;
    (s_reg.seq == seq_tx_state) |-> chip_mode == MODE_TX;
  endproperty
  a_tx_on: assert property (p_tx_on)
    else $error("transmit state without transmitter");

  c_restart_relock: cover property (rx_ctl.rx_restart && rx_ctl.restart_relock);
  c_collision: cover property (coll_go);
  c_got_frame: cover property (s_reg.seq == seq_got_frame_state);
  c_timeout: cover property (|rx_ctl.timeout_irq);
endmodule : fsrs_top

/* verilog/fsrs_pkg.sv */
// constants, types and state layout of the receiver restart sequencer
package fsrs_pkg;
  // ****************************************
  // register bus and map
  // ****************************************
  localparam int          DW             = 8;
  localparam int          AW             = 6;
  localparam logic [5:0]  ADR_RX_CFG     = 6'h00;
  localparam logic [5:0]  ADR_SYNC_CFG   = 6'h04;
  localparam logic [5:0]  ADR_SEQ_CFG    = 6'h08;
  localparam logic [5:0]  ADR_FRONT_AMP  = 6'h0C;
  localparam logic [5:0]  ADR_COLL_THR   = 6'h10;
  localparam logic [5:0]  ADR_POST_WAIT  = 6'h14;
  localparam logic [5:0]  ADR_TO_BASE    = 6'h18;
  localparam logic [5:0]  ADR_STATUS     = 6'h24;
  localparam logic [5:0]  ADR_STEP       = 6'h04;
  // receiver_setup_reg fields
  localparam int          RXC_COLL       = 7;
  localparam int          RXC_KEEP       = 6;
  localparam int          RXC_RELOCK     = 5;
  localparam int          RXC_AFC        = 4;
  localparam int          RXC_AGC        = 3;
  localparam logic [7:0]  RXC_STORE_MASK = 8'h9F;
  // sequencer_setup_reg fields
  localparam int          SEQ_START      = 7;
  localparam int          SEQ_STOP       = 6;
  localparam int          SEQ_QUIET      = 5;
  localparam int          SEQ_ROUTE_LO   = 3;
  localparam int          SEQ_REST       = 2;
  localparam int          SEQ_EXP_RESTART = 0;
  localparam logic [7:0]  SEQ_STORE_MASK = 8'h3F;
  // status fields
  localparam int          STAT_ACTIVE    = 7;
  localparam int          STAT_STATE_LO  = 4;
  // codes
  localparam logic [2:0]  TRIG_NONE      = 3'h0;
  localparam logic [2:0]  TRIG_RSSI      = 3'h1;
  localparam logic [2:0]  TRIG_PRE       = 3'h6;
  localparam logic [2:0]  TRIG_BOTH      = 3'h7;
  localparam logic [1:0]  AR_OFF         = 2'h0;
  localparam logic [1:0]  AR_RELOCK      = 2'h2;
  localparam logic [1:0]  RT_REST        = 2'h0;
  localparam logic [1:0]  RT_RX          = 2'h1;
  localparam logic [1:0]  RT_TX          = 2'h2;
  localparam logic [2:0]  MODE_SLEEP     = 3'h0;
  localparam logic [2:0]  MODE_STBY      = 3'h1;
  localparam logic [2:0]  MODE_TX        = 3'h3;
  localparam logic [2:0]  MODE_RX        = 3'h5;
  // ****************************************
  // timing
  // ****************************************
  localparam int          NUM_TO         = 3;
  localparam int          TIMEOUT_SCALE  = 16;
  localparam int          CLK_PERIOD_NS  = 4;
  localparam int          RELOCK_TIME_NS = 20000;
  localparam int          RELOCK_CYC_DEF = (RELOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    seq_halted_state        = 3'h0,
    seq_idle_state          = 3'h1,
    seq_tx_state            = 3'h2,
    seq_rx_state            = 3'h3,
    seq_got_frame_state     = 3'h4,
    seq_rest_choice_state   = 3'h5,
    seq_listen_expiry_state = 3'h6,
    seq_fifo_wait_state     = 3'h7
  } fsrs_seq_t;
  typedef enum logic [1:0] {
    ar_idle  = 2'h0,
    ar_empty = 2'h1,
    ar_delay = 2'h2,
    ar_lock  = 2'h3
  } fsrs_ar_t;
  typedef struct packed {
    logic rssi_irq;
    logic lead_in_found_flag;
    logic sync_found_flag;
    logic packet_ready_flag;
    logic fifo_empty;
    logic fifo_thr_irq;
    logic packet_sent;
    logic seq_timer_one;
    logic seq_timer_two;
    logic bit_tick;
  } fsrs_rx_ev_t;
  typedef struct packed {
    logic                rx_restart;
    logic                restart_relock;
    logic                gain_corr_start;
    logic                freq_corr_start;
    logic                gain_manual;
    logic [2:0]          front_gain;
    logic [NUM_TO-1:0]   timeout_irq;
  } fsrs_rx_ctl_t;
  typedef struct packed {
    fsrs_seq_t              seq;
    logic                   seq_ran;
    logic [2:0]             init_mode;
    logic [2:0]             mode;
    logic [7:0]             rx_cfg;
    logic [1:0]             sync_cfg;
    logic [7:0]             seq_cfg;
    logic [2:0]             gain;
    logic [7:0]             coll_thr;
    logic [7:0]             post_wait;
    logic [NUM_TO-1:0][7:0] to_val;
    logic [NUM_TO-1:0]      seen;
    logic [11:0]            bit_cnt;
    logic [7:0]             rssi_prev;
    logic                   arm;
    fsrs_ar_t               ar;
    logic [15:0]            ar_cnt;
    logic [7:0]             rdata;
    fsrs_rx_ctl_t           ctl;
  } fsrs_state_t;
endpackage : fsrs_pkg

/* bench/fsrs_radio_model.sv */
// receive chain model: bit clock, event levels and mode settling
`timescale 1ns/100ps
module fsrs_radio_model
#(
  parameter int TICK = 4
)
(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset,
  // stimulus and chip mode
  input  wire fsrs_pkg::fsrs_rx_ev_t ev_set,
  input  wire logic [2:0]            chip_mode,
  // towards the block
  output fsrs_pkg::fsrs_rx_ev_t      rx_ev,
  output logic                       mode_settled_flag
);
  import fsrs_pkg::*;
  int         tcnt;
  int         scnt;
  logic [2:0] mode_q;
  // settling takes four cycles after every mode change
  always_ff @(posedge clk)
  begin
    tcnt   <= (reset || tcnt == TICK - 1) ? 0 : tcnt + 1;
    mode_q <= chip_mode;
    scnt   <= reset ? 3 : (mode_q != chip_mode) ? 3 : (scnt > 0) ? scnt - 1 : 0;
  end
  assign mode_settled_flag = (scnt == 0) && (mode_q == chip_mode);
  always_comb
  begin
    rx_ev          = ev_set;
    rx_ev.bit_tick = (tcnt == TICK - 1);
  end
endmodule : fsrs_radio_model

/* bench/tb.sv */
// self-checking bench of the receiver restart sequencer
`timescale 1ns/100ps
module tb;
  import fsrs_pkg::*;
  logic         clk, reset, we, re, spread_mode, settled;
  logic [5:0]   addr;
  logic [7:0]   wdata, rdata, rssi_value, d;
  logic [2:0]   host_mode, chip_mode;
  logic         seq_active;
  fsrs_rx_ev_t  ev_set, rx_ev;
  fsrs_rx_ctl_t rx_ctl;
  int           error_cnt, n_compared, cyc_n, rcnt, gcnt, fcnt, toc, rt, tt, r0, g0, f0, c0;
  int           t[3];
  logic [2:0]   codes[4] = '{TRIG_NONE, TRIG_RSSI, TRIG_PRE, TRIG_BOTH};
  fsrs_top #(.RELOCK_CYC(8)) dut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
    .we(we), .re(re), .rdata(rdata), .mode_settled_flag(settled), .spread_mode(spread_mode),
    .host_mode(host_mode), .rssi_value(rssi_value), .rx_ev(rx_ev), .rx_ctl(rx_ctl),
    .chip_mode(chip_mode), .seq_active(seq_active));
  fsrs_radio_model radio (.clk(clk), .reset(reset), .ev_set(ev_set), .chip_mode(chip_mode),
    .rx_ev(rx_ev), .mode_settled_flag(settled));
  // ****************************************
  // clock and event counters
  // ****************************************
  initial
  begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc_n <= cyc_n + 1;
    rcnt  <= rcnt + int'(rx_ctl.rx_restart === 1'b1);
    gcnt  <= gcnt + int'(rx_ctl.gain_corr_start === 1'b1);
    fcnt  <= fcnt + int'(rx_ctl.freq_corr_start === 1'b1);
    toc   <= toc + int'(rx_ctl.timeout_irq[0] === 1'b1);
    if (rx_ctl.rx_restart === 1'b1)
      rt <= cyc_n;
    if (rx_ctl.timeout_irq[0] === 1'b1)
      tt <= cyc_n;
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("FAIL %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    we    <= 1'b1;
    @(posedge clk);
    we    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a);
    @(posedge clk);
    addr <= a;
    re   <= 1'b1;
    @(posedge clk);
    re   <= 1'b0;
    #1 d = rdata;
  endtask : rd
  task automatic pulse(input fsrs_rx_ev_t m);
    @(posedge clk);
    ev_set <= ev_set | m;
    @(posedge clk);
    ev_set <= ev_set & ~m;
  endtask : pulse
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_manual;
    rd(6'h3C);
    chk(d, 8'h00);
    host_mode <= MODE_RX;
    r0 = rcnt;
    wr(ADR_RX_CFG, 8'h40);
    cyc(2);
    chk(rcnt - r0, 0);
    cyc(6);
    wr(ADR_RX_CFG, 8'h20);
    #1 chk({rx_ctl.rx_restart, rx_ctl.restart_relock}, 2'h3);
    @(posedge clk);
    #1 chk(rx_ctl.rx_restart, 1'b0);
    wr(ADR_RX_CFG, 8'h40);
    #1 chk({rx_ctl.rx_restart, rx_ctl.restart_relock}, 2'h2);
    rd(ADR_RX_CFG);
    chk(d[6:5], 2'h0);
  endtask : t_manual
  task automatic t_corr;
    foreach (codes[i])
    begin
      wr(ADR_RX_CFG, {5'h03, codes[i]});
      wr(ADR_RX_CFG, {5'h07, codes[i]});
      g0 = gcnt;
      f0 = fcnt;
      ev_set.rssi_irq <= 1'b1;
      cyc(4);
      chk(gcnt - g0, codes[i][0]);
      chk(fcnt - f0, codes[i][0]);
      ev_set.lead_in_found_flag <= 1'b1;
      cyc(4);
      chk(gcnt - g0, codes[i] != TRIG_NONE);
      ev_set <= '0;
    end
    wr(ADR_FRONT_AMP, 8'h05);
    wr(ADR_RX_CFG, 8'h31);
    g0 = gcnt;
    f0 = fcnt;
    ev_set.rssi_irq <= 1'b1;
    cyc(4);
    chk(gcnt - g0 + fcnt - f0, 0);
    chk({rx_ctl.gain_manual, rx_ctl.front_gain}, 4'hD);
    ev_set <= '0;
  endtask : t_corr
  task automatic t_auto;
    wr(ADR_POST_WAIT, 8'h02);
    for (int s = 0; s < 3; s++)
    begin
      wr(ADR_SYNC_CFG, 8'(s));
      ev_set.packet_ready_flag <= 1'b1;
      cyc(3);
      @(posedge clk iff rx_ev.bit_tick);
      ev_set <= 10'h020;
      r0 = rcnt;
      c0 = cyc_n;
      repeat (40) if (rcnt == r0) @(posedge clk);
      t[s] = rt - c0;
      chk(rcnt - r0, s != 0);
      ev_set <= '0;
    end
    chk(t[1] >= 5 && t[1] <= 12, 1'b1);
    // lock count of 8 runs down to zero, then one more cycle to fire
    chk(t[2] - t[1], 8 + 1);
    wr(ADR_SYNC_CFG, 8'h00);
  endtask : t_auto
  task automatic t_coll;
    wr(ADR_COLL_THR, 8'h05);
    wr(ADR_RX_CFG, 8'h80);
    rssi_value <= 8'h14;
    cyc(12);
    r0 = rcnt;
    rssi_value <= 8'h19;
    cyc(12);
    chk(rcnt - r0, 0);
    rssi_value <= 8'h1F;
    cyc(12);
    chk(rcnt - r0, 1);
    wr(ADR_RX_CFG, 8'h00);
    rssi_value <= 8'h40;
    cyc(12);
    chk(rcnt - r0, 1);
  endtask : t_coll
  task automatic t_timeout;
    wr(ADR_TO_BASE, 8'h01);
    r0 = toc;
    wr(ADR_RX_CFG, 8'h40);
    c0 = cyc_n;
    repeat (100) if (toc == r0) @(posedge clk);
    chk(toc - r0, 1);
    chk((tt - c0) inside {[58:72]}, 1'b1);
    wr(ADR_TO_BASE, 8'h00);
  endtask : t_timeout
  task automatic t_seq;
    host_mode <= MODE_STBY;
    cyc(8);
    wr(ADR_SEQ_CFG, 8'h90); // start with route to transmit, stop bit clear
    cyc(3);
    chk({seq_active, chip_mode}, {1'b1, MODE_TX});
    pulse(10'h008);
    cyc(4);
    chk({seq_active, chip_mode}, {1'b0, MODE_STBY});
    wr(ADR_SEQ_CFG, 8'hA4);
    cyc(3);
    pulse(10'h008);
    cyc(3);
    chk({seq_active, chip_mode}, {1'b1, MODE_SLEEP});
    pulse(10'h004);
    cyc(3);
    rd(ADR_STATUS);
    chk(d, {1'b1, seq_rx_state, 1'b0, MODE_RX});
    wr(ADR_SEQ_CFG, 8'h40);
    @(posedge clk);
    #1 chk(seq_active, 1'b0);
    wr(ADR_SEQ_CFG, 8'h84);
    cyc(3);
    chk({seq_active, chip_mode}, {1'b1, MODE_STBY});
    wr(ADR_SEQ_CFG, 8'h40);
    wr(ADR_SEQ_CFG, 8'h98);
    cyc(3);
    pulse(10'h010);
    cyc(3);
    chk({seq_active, chip_mode}, {1'b1, MODE_TX});
    wr(ADR_TO_BASE + ADR_STEP, 8'h01);
    wr(ADR_SEQ_CFG, 8'h40);
    wr(ADR_SEQ_CFG, 8'h89);
    r0 = rcnt;
    cyc(80);
    chk(rcnt - r0, 1);
    chk({seq_active, chip_mode}, {1'b1, MODE_RX});
    wr(ADR_SEQ_CFG, 8'h40);
    wr(ADR_TO_BASE + ADR_STEP, 8'h00);
    cyc(3);
    spread_mode <= 1'b1;
    wr(ADR_SEQ_CFG, 8'h88);
    cyc(3);
    chk(seq_active, 1'b0);
  endtask : t_seq
  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial
  begin
    {reset, we, re, spread_mode, addr, wdata, rssi_value, ev_set} = '0;
    reset     = 1'b1;
    host_mode = MODE_SLEEP;
    {error_cnt, n_compared, cyc_n, rcnt, gcnt, fcnt, toc, rt, tt} = '0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    t_manual();
    t_corr();
    t_auto();
    t_coll();
    t_timeout();
    t_seq();
    complete_run();
  end
  initial
  begin
    #100000;
    error_cnt++;
    complete_run();
  end
endmodule : tb
